// file: halt_wake_pkg.sv
// constants for the halt mode and auto-wake controller
// assumes a 10 MHz ref_clk and an APB register port with 32-bit data
package halt_wake_pkg;
    // printed offsets 0x49 and 0x4A are not multiples of four: they are indices
    localparam logic [7:0]  PRESCALER_IDX     = 8'h49;
    localparam logic [7:0]  CTRL_STATUS_IDX   = 8'h4A;
    localparam logic [7:0]  HALT_CTRL_IDX     = 8'h4C;
    localparam logic [11:0] PRESCALER_ADDR    = {2'b00, PRESCALER_IDX, 2'b00};
    localparam logic [11:0] CTRL_STATUS_ADDR  = {2'b00, CTRL_STATUS_IDX, 2'b00};
    localparam logic [11:0] HALT_CTRL_ADDR    = {2'b00, HALT_CTRL_IDX, 2'b00};
    localparam logic [7:0]  PRESCALER_RESET   = 8'hFF;
    localparam logic [7:0]  CTRL_STATUS_RESET = 8'h00;
    localparam logic [7:0]  PRESCALER_ZERO    = 8'h00;
    // control/status field positions
    localparam int          ENABLE_BIT        = 0;
    localparam int          MEASURE_BIT       = 1;
    localparam int          FLAG_BIT          = 2;
    // halt control field positions
    localparam int          LONG_START_BIT    = 0;
    localparam int          PLL_ON_BIT        = 1;
    localparam int          WDG_HALT_BIT      = 2;
    localparam int          ZERO_IRQ_BIT      = 3;
    // start-up delays in cpu cycles
    localparam int          SHORT_START_CYC   = 256;
    localparam int          LONG_START_CYC    = 4096;
    // pll start-up delay, in ns
    localparam int          PLL_START_NS      = 1000;
    localparam int          CLK_PERIOD_NS     = 100;
    localparam int          PLL_START_CYC     = (PLL_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W             = 13;
    typedef enum logic [4:0] {
        ST_RUN    = 5'b00001,
        ST_ACTIVE = 5'b00010,
        ST_AUTO   = 5'b00100,
        ST_HALT   = 5'b01000,
        ST_START  = 5'b10000
    } halt_state_e;
endpackage : halt_wake_pkg

// file: wake_period_counter.sv
// counts wake rc edges through the prescaler factor
// assumes wake_rc_tick is a synchronised one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module wake_period_counter
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    input  wire logic       run,
    input  wire logic       wake_rc_tick,
    input  wire logic [7:0] factor,
    output logic            done
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       done_r;
    logic       done_nxt;

    always_comb
    begin
        cnt_nxt  = cnt_r;
        done_nxt = 1'b0;
        if (!run)
        begin
            cnt_nxt = 8'h00;
        end
        else if (wake_rc_tick)
        begin
            if (cnt_r + 8'h01 >= factor)
            begin
                cnt_nxt  = 8'h00;
                done_nxt = 1'b1;
            end
            else
            begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_r  <= 8'h00;
            done_r <= 1'b0;
        end
        else if (clk_en)
        begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule : wake_period_counter
`default_nettype wire

// file: halt_mode_auto_wakeup_control.sv
// halt mode selection, auto-wake timer, start-up delay and registers
// assumes cpu strobes halt_exec for one cycle; wake_rc_clk and irq pins asynchronous
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - timer enables select timed halt mode
// - reset exit waits 256 or 4096
// - interrupt exit resumes with no delay
// - timed halt entry clears interrupt mask
// - only oscillator and timer clocked
// - timed halt blocks watchdog reset
// - only time base, specific irqs wake
// - enable bit selects auto-wake halt
// - auto-wake halt stops main oscillator
// - auto-wake entry clears interrupt mask
// - reset or halt-capable irq exits
// - option bit decides watchdog reset
// - measure bit routes rc to capture
// - flag set by hardware, read clears
// - enable bit makes timed self-wake
// - prescaler divides by its value
// - zero prescaler handled per option
// - pll gives clock after extra delay
// - oscillator-off exit waits stabilisation delay
module halt_mode_auto_wakeup_control
#(
    parameter int LONG_START = halt_wake_pkg::LONG_START_CYC
)
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        halt_exec,
    input  wire logic        wake_reset_req,
    input  wire logic        lite_timer_base_irq_enable,
    input  wire logic        autoreload_overflow_irq_enable,
    input  wire logic [1:0]  autoreload_clock_select,
    input  wire logic        realtime_base_interrupt,
    input  wire logic        halt_capable_irq,
    input  wire logic        watchdog_enabled,
    input  wire logic        watchdog_halt_option,
    input  wire logic        wake_rc_clk,
    output logic             auto_wake_irq,
    output logic             irq_mask_clear,
    output logic             main_osc_on,
    output logic             timer_clk_en,
    output logic             periph_clk_en,
    output logic             cpu_run,
    output logic             fetch_reset_vector,
    output logic             service_irq,
    output logic             watchdog_reset,
    output logic             wake_rc_on,
    output logic             capture_input,
    output logic             pll_clk_valid,
    output logic             auto_wake_halt_mode
);
    localparam int PLL_W = 8;

    halt_wake_pkg::halt_state_e state_r;
    halt_wake_pkg::halt_state_e state_nxt;
    logic [7:0]               prescaler_r;
    logic [7:0]               prescaler_nxt;
    logic [2:0]               csr_r;
    logic [2:0]               csr_nxt;
    logic [3:0]               hctl_r;
    logic [3:0]               hctl_nxt;
    logic [halt_wake_pkg::CNT_W-1:0] start_cnt_r;
    logic [halt_wake_pkg::CNT_W-1:0] start_cnt_nxt;
    logic [PLL_W-1:0]         pll_cnt_r;
    logic [PLL_W-1:0]         pll_cnt_nxt;
    logic                     from_reset_r;
    logic                     from_reset_nxt;
    logic [31:0]              prdata_r;
    logic [31:0]              prdata_nxt;
    logic [2:0]               sync_rc_r;
    logic [1:0]               sync_rst_r;
    logic [1:0]               sync_irq_r;
    logic [1:0]               sync_rtb_r;
    logic                     period_done;
    logic                     zero_irq;
    logic                     rc_tick;
    logic                     timed_ok;
    logic                     wr;
    logic                     rd;
    logic                     rd_setup;
    logic                     wake_irq;
    logic                     rst_req;

    function automatic logic [halt_wake_pkg::CNT_W-1:0] start_len(input logic long_sel);
        start_len = long_sel ? halt_wake_pkg::CNT_W'(LONG_START)
                             : halt_wake_pkg::CNT_W'(halt_wake_pkg::SHORT_START_CYC);
    endfunction : start_len

    // last cycle of the start-up delay
    function automatic logic start_last(input logic [halt_wake_pkg::CNT_W-1:0] cnt);
        start_last = (cnt <= halt_wake_pkg::CNT_W'(1));
    endfunction : start_last

    // pins from outside the clock domain
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_rc_r  <= 3'b000;
            sync_rst_r <= 2'b00;
            sync_irq_r <= 2'b00;
            sync_rtb_r <= 2'b00;
        end
        else if (clk_en)
        begin
            sync_rc_r  <= {sync_rc_r[1:0], wake_rc_clk};
            sync_rst_r <= {sync_rst_r[0], wake_reset_req};
            sync_irq_r <= {sync_irq_r[0], halt_capable_irq};
            sync_rtb_r <= {sync_rtb_r[0], realtime_base_interrupt};
        end
    end

    assign rc_tick = sync_rc_r[1] & ~sync_rc_r[2];
    assign rst_req = sync_rst_r[1];
    assign wr      = psel & penable & pwrite;
    assign rd      = psel & penable & ~pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;

    assign timed_ok = lite_timer_base_irq_enable
                    | (autoreload_overflow_irq_enable & (autoreload_clock_select == 2'b01));

    assign wake_irq = sync_irq_r[1] | ((state_r == halt_wake_pkg::ST_ACTIVE) & sync_rtb_r[1]);

    assign zero_irq = hctl_r[halt_wake_pkg::ZERO_IRQ_BIT] & (prescaler_r == halt_wake_pkg::PRESCALER_ZERO)
                    & (state_r == halt_wake_pkg::ST_AUTO);

    wake_period_counter u_period
    (
        .ref_clk      (ref_clk),
        .resetn       (resetn),
        .clk_en       (clk_en),
        .run          (state_r == halt_wake_pkg::ST_AUTO),
        .wake_rc_tick (rc_tick),
        .factor       (prescaler_r),
        .done         (period_done)
    );

    always_comb
    begin
        state_nxt      = state_r;
        start_cnt_nxt  = start_cnt_r;
        from_reset_nxt = from_reset_r;
        pll_cnt_nxt    = pll_cnt_r;
        unique case (state_r)
            halt_wake_pkg::ST_RUN:
            begin
                if (halt_exec)
                begin
                    if (csr_r[halt_wake_pkg::ENABLE_BIT])
                        state_nxt = halt_wake_pkg::ST_AUTO;
                    else if (timed_ok)
                        state_nxt = halt_wake_pkg::ST_ACTIVE;
                    else
                        state_nxt = halt_wake_pkg::ST_HALT;
                end
                if (pll_cnt_r != '0)
                    pll_cnt_nxt = pll_cnt_r - PLL_W'(1);
            end
            halt_wake_pkg::ST_ACTIVE:
            begin
                if (rst_req)
                begin
                    state_nxt      = halt_wake_pkg::ST_START;
                    start_cnt_nxt  = start_len(hctl_r[halt_wake_pkg::LONG_START_BIT]);
                    from_reset_nxt = 1'b1;
                end
                else if (wake_irq)
                    state_nxt = halt_wake_pkg::ST_RUN;
            end
            halt_wake_pkg::ST_AUTO, halt_wake_pkg::ST_HALT:
            begin
                if (rst_req | wake_irq | period_done | zero_irq)
                begin
                    state_nxt      = halt_wake_pkg::ST_START;
                    start_cnt_nxt  = start_len(hctl_r[halt_wake_pkg::LONG_START_BIT]);
                    from_reset_nxt = rst_req;
                end
            end
            halt_wake_pkg::ST_START:
            begin
                if (!start_last(start_cnt_r))
                    start_cnt_nxt = start_cnt_r - halt_wake_pkg::CNT_W'(1);
                else
                begin
                    state_nxt = halt_wake_pkg::ST_RUN;
                    if (hctl_r[halt_wake_pkg::PLL_ON_BIT])
                        pll_cnt_nxt = PLL_W'(halt_wake_pkg::PLL_START_CYC);
                end
            end
            default:
                state_nxt = halt_wake_pkg::ST_RUN;
        endcase
    end

    always_comb
    begin
        prescaler_nxt = prescaler_r;
        csr_nxt       = csr_r;
        hctl_nxt      = hctl_r;
        prdata_nxt    = prdata_r;
        if (wr)
        begin
            if (paddr == halt_wake_pkg::PRESCALER_ADDR)
                prescaler_nxt = pwdata[7:0];
            if (paddr == halt_wake_pkg::CTRL_STATUS_ADDR)
            begin
                csr_nxt[halt_wake_pkg::ENABLE_BIT]  = pwdata[halt_wake_pkg::ENABLE_BIT];
                csr_nxt[halt_wake_pkg::MEASURE_BIT] = pwdata[halt_wake_pkg::MEASURE_BIT];
            end
            if (paddr == halt_wake_pkg::HALT_CTRL_ADDR)
                hctl_nxt = pwdata[3:0];
        end
        // read data loaded at setup so it stands through the access phase
        if (rd_setup)
        begin
            unique case (paddr)
                halt_wake_pkg::PRESCALER_ADDR:   prdata_nxt = {24'h000000, prescaler_r};
                halt_wake_pkg::CTRL_STATUS_ADDR: prdata_nxt = {29'h00000000, csr_r};
                halt_wake_pkg::HALT_CTRL_ADDR:   prdata_nxt = {28'h0000000, hctl_r};
                default:                         prdata_nxt = 32'h00000000;
            endcase
        end
        if (rd)
        begin
            if (paddr == halt_wake_pkg::CTRL_STATUS_ADDR)
                csr_nxt[halt_wake_pkg::FLAG_BIT] = 1'b0;
        end
        if (period_done | zero_irq)
            csr_nxt[halt_wake_pkg::FLAG_BIT] = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r      <= halt_wake_pkg::ST_RUN;
            start_cnt_r  <= '0;
            from_reset_r <= 1'b0;
            pll_cnt_r    <= '0;
            prescaler_r  <= halt_wake_pkg::PRESCALER_RESET;
            csr_r        <= halt_wake_pkg::CTRL_STATUS_RESET[2:0];
            hctl_r       <= 4'h0;
            prdata_r     <= 32'h00000000;
        end
        else if (clk_en)
        begin
            state_r      <= state_nxt;
            start_cnt_r  <= start_cnt_nxt;
            from_reset_r <= from_reset_nxt;
            pll_cnt_r    <= pll_cnt_nxt;
            prescaler_r  <= prescaler_nxt;
            csr_r        <= csr_nxt;
            hctl_r       <= hctl_nxt;
            prdata_r     <= prdata_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    assign irq_mask_clear = (state_r == halt_wake_pkg::ST_RUN) & halt_exec;
    always_comb
    begin
        main_osc_on   = 1'b1;
        timer_clk_en  = 1'b0;
        periph_clk_en = 1'b0;
        cpu_run       = 1'b0;
        unique case (state_r)
            halt_wake_pkg::ST_RUN:
            begin
                timer_clk_en  = 1'b1;
                periph_clk_en = 1'b1;
                cpu_run       = 1'b1;
            end
            halt_wake_pkg::ST_ACTIVE:
            begin
                timer_clk_en  = 1'b1;
            end
            halt_wake_pkg::ST_AUTO, halt_wake_pkg::ST_HALT:
            begin
                main_osc_on   = 1'b0;
            end
            halt_wake_pkg::ST_START:
            begin
                main_osc_on   = 1'b1;
            end
            default:
            begin
                main_osc_on   = 1'b1;
            end
        endcase
    end
    assign fetch_reset_vector = (state_r == halt_wake_pkg::ST_START) & start_last(start_cnt_r) & from_reset_r;
    assign service_irq    = ((state_r == halt_wake_pkg::ST_ACTIVE) & ~rst_req & wake_irq)
                          | ((state_r == halt_wake_pkg::ST_START) & start_last(start_cnt_r) & ~from_reset_r);
    always_comb
    begin
        watchdog_reset = 1'b0;
        if ((state_r == halt_wake_pkg::ST_RUN) & halt_exec & watchdog_enabled)
        begin
            if (csr_r[halt_wake_pkg::ENABLE_BIT])
                watchdog_reset = ~watchdog_halt_option;
            else if (timed_ok)
                watchdog_reset = 1'b0;
            else
                watchdog_reset = ~watchdog_halt_option;
        end
    end
    assign wake_rc_on     = (state_r == halt_wake_pkg::ST_AUTO)
                          | (csr_r[halt_wake_pkg::MEASURE_BIT] & (state_r == halt_wake_pkg::ST_RUN));
    assign capture_input  = csr_r[halt_wake_pkg::MEASURE_BIT] & (state_r == halt_wake_pkg::ST_RUN) & sync_rc_r[1];
    assign pll_clk_valid  = (state_r == halt_wake_pkg::ST_RUN) & (pll_cnt_r == '0);
    assign auto_wake_irq  = csr_r[halt_wake_pkg::FLAG_BIT];
    assign auto_wake_halt_mode = (state_r == halt_wake_pkg::ST_AUTO);
endmodule : halt_mode_auto_wakeup_control
`default_nettype wire

// file: halt_wake_properties.sv
// port assertions for the halt mode and auto-wake controller
// assumes the short start-up delay is selected and clk_en is held high
`timescale 1ns/1ps
`default_nettype none
module halt_wake_properties
#(
    parameter int LONG_START = 16
)
(
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        halt_exec,
    input wire logic        watchdog_enabled,
    input wire logic        watchdog_halt_option,
    input wire logic        auto_wake_irq,
    input wire logic        irq_mask_clear,
    input wire logic        main_osc_on,
    input wire logic        cpu_run,
    input wire logic        watchdog_reset,
    input wire logic        wake_rc_on,
    input wire logic        auto_wake_halt_mode
);
    logic en_r;
    logic en_nxt;
    logic meas_r;
    logic meas_nxt;
    logic csr_acc;
    assign csr_acc = clk_en && psel && penable && paddr == halt_wake_pkg::CTRL_STATUS_ADDR;
    always_comb
    begin
        en_nxt   = (csr_acc && pwrite) ? pwdata[0] : en_r;
        meas_nxt = (csr_acc && pwrite) ? pwdata[1] : meas_r;
    end
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            en_r   <= 1'b0;
            meas_r <= 1'b0;
        end
        else
        begin
            en_r   <= en_nxt;
            meas_r <= meas_nxt;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_halt_exit;
        $fell(auto_wake_halt_mode);
    endsequence
    sequence s_resume;
        ##[250:262] $rose(cpu_run);
    endsequence
    a_auto_entry: assert property (clk_en && halt_exec && cpu_run && en_r && !watchdog_enabled |=>
        auto_wake_halt_mode) else $error("auto-wake halt not entered");
    a_auto_osc_off: assert property (auto_wake_halt_mode |-> !main_osc_on && !cpu_run)
        else $error("oscillator or cpu running in auto-wake halt");
    a_auto_mask_clear: assert property ($rose(auto_wake_halt_mode) |-> irq_mask_clear || $past(irq_mask_clear))
        else $error("interrupt mask not cleared on halt entry");
    a_flag_read_value: assert property (csr_acc && !pwrite |-> prdata[2] == $past(auto_wake_irq))
        else $error("flag read value wrong");
    a_flag_read_clear: assert property (csr_acc && !pwrite && !auto_wake_halt_mode |=> !auto_wake_irq)
        else $error("flag not cleared by read");
    a_reserved_zero: assert property (csr_acc && !pwrite |-> prdata[31:3] == 29'h0)
        else $error("reserved bits not zero");
    a_wdg_option: assert property (clk_en && halt_exec && cpu_run && en_r && watchdog_enabled |->
        watchdog_reset == !watchdog_halt_option) else $error("watchdog reset against option");
    a_measure_rc_on: assert property (cpu_run && meas_r |-> wake_rc_on)
        else $error("rc oscillator off while measuring");
    a_start_delay: assert property (s_halt_exit |-> s_resume)
        else $error("start-up delay wrong");
endmodule : halt_wake_properties
bind halt_mode_auto_wakeup_control halt_wake_properties #(.LONG_START(LONG_START)) u_props (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .halt_exec(halt_exec),
    .watchdog_enabled(watchdog_enabled), .watchdog_halt_option(watchdog_halt_option),
    .auto_wake_irq(auto_wake_irq), .irq_mask_clear(irq_mask_clear), .main_osc_on(main_osc_on),
    .cpu_run(cpu_run), .watchdog_reset(watchdog_reset), .wake_rc_on(wake_rc_on),
    .auto_wake_halt_mode(auto_wake_halt_mode));
`default_nettype wire

// file: wake_rc_model.sv
// wake-up rc oscillator standing beside the controller
// assumes it is started and stopped by the controller's enable
`timescale 1ns/1ps
`default_nettype none
module wake_rc_model
#(
    parameter int HALF_NS = 730
)
(
    input  wire logic enable,
    output logic      rc_clk
);
    initial rc_clk = 1'b0;
    always
    begin
        wait (enable === 1'b1);
        #(HALF_NS) rc_clk = enable ? ~rc_clk : 1'b0;
    end
endmodule : wake_rc_model
`default_nettype wire

// file: testbench.sv
// self-checking bench for the halt mode and auto-wake controller
// assumes zero-wait apb slave with read data standing during the access phase
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        ref_clk, resetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        halt_exec, wake_reset_req, lite_en, ovf_en, rtb_irq, hc_irq, wdg_en, wdg_opt, rc_clk;
    logic [1:0]  clk_sel;
    logic        awu_irq, mask_clr, osc_on, tmr_en, per_en, cpu_run, fetch_rv, svc_irq, wdg_rst, rc_on, cap_in, pll_ok;
    int          failures, compares, cycles, n, svc, wdg, fetch;
    halt_mode_auto_wakeup_control #(.LONG_START(16)) DUT (.ref_clk(ref_clk), .resetn(resetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec),
        .wake_reset_req(wake_reset_req), .lite_timer_base_irq_enable(lite_en),
        .autoreload_overflow_irq_enable(ovf_en), .autoreload_clock_select(clk_sel),
        .realtime_base_interrupt(rtb_irq), .halt_capable_irq(hc_irq), .watchdog_enabled(wdg_en),
        .watchdog_halt_option(wdg_opt), .wake_rc_clk(rc_clk), .auto_wake_irq(awu_irq),
        .irq_mask_clear(mask_clr), .main_osc_on(osc_on), .timer_clk_en(tmr_en), .periph_clk_en(per_en),
        .cpu_run(cpu_run), .fetch_reset_vector(fetch_rv), .service_irq(svc_irq), .watchdog_reset(wdg_rst),
        .wake_rc_on(rc_on), .capture_input(cap_in), .pll_clk_valid(pll_ok), .auto_wake_halt_mode());
    wake_rc_model RC (.enable(rc_on), .rc_clk(rc_clk));
    always #50 ref_clk = ~ref_clk;
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    always @(posedge ref_clk)
    begin
        cycles++;
        svc   += (svc_irq === 1'b1);
        wdg   += (wdg_rst === 1'b1);
        fetch += (fetch_rv === 1'b1);
        if (cycles == 20000)
        begin
            failures++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task automatic halt;
        @(posedge ref_clk);
        halt_exec <= 1'b1;
        @(posedge ref_clk);
        halt_exec <= 1'b0;
        #1;
    endtask : halt
    task automatic wait_hi(input bit flag);
        n = 0;
        while (((flag ? awu_irq : cpu_run) !== 1'b1) && n < 1000)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
    endtask : wait_hi
    initial
    begin
        {ref_clk, resetn, psel, penable, pwrite, paddr, pwdata, halt_exec, wake_reset_req} = '0;
        {lite_en, ovf_en, clk_sel, rtb_irq, hc_irq, wdg_en, wdg_opt} = '0;
        clk_en = 1'b1;
        {failures, compares, cycles, svc, wdg, fetch} = '0;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        apb(0, halt_wake_pkg::PRESCALER_ADDR, 0); check(rd, 32'h000000FF);
        apb(0, halt_wake_pkg::CTRL_STATUS_ADDR, 0); check(rd, 32'h00000000);
        apb(0, 12'h004, 0); check(rd, 32'h00000000);
        apb(1, halt_wake_pkg::PRESCALER_ADDR, 32'h03);
        apb(0, halt_wake_pkg::PRESCALER_ADDR, 0); check(rd, 32'h00000003);
        apb(1, halt_wake_pkg::CTRL_STATUS_ADDR, 32'hFC);
        apb(0, halt_wake_pkg::CTRL_STATUS_ADDR, 0); check(rd, 32'h00000000);
        $display("test registers done");
        apb(1, halt_wake_pkg::CTRL_STATUS_ADDR, 32'h01);
        halt();
        check({osc_on, cpu_run}, 2'b00);
        wait_hi(1); check(n >= 20 && n <= 60, 1);
        wait_hi(0); check(n >= 245 && n <= 265, 1);
        apb(0, halt_wake_pkg::CTRL_STATUS_ADDR, 0); check(rd, 32'h00000005);
        apb(0, halt_wake_pkg::CTRL_STATUS_ADDR, 0); check(rd, 32'h00000001);
        $display("test auto wake done");
        apb(1, halt_wake_pkg::CTRL_STATUS_ADDR, 32'h00);
        {svc, wdg} = '0;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge ref_clk);
            wdg_en  <= 1'b1;
            wdg_opt <= 1'b0;
            lite_en <= (i == 0);
            ovf_en  <= (i == 1);
            clk_sel <= 2'b01;
            halt();
            check({cpu_run, osc_on, tmr_en, per_en}, 4'b0110);
            check(wdg, 0);
            @(posedge ref_clk);
            rtb_irq <= 1'b1;
            wait_hi(0); check(n <= 6 && svc == i + 1, 1);
            rtb_irq <= 1'b0;
        end
        $display("test active halt done");
        apb(1, halt_wake_pkg::HALT_CTRL_ADDR, 32'h02);
        apb(1, halt_wake_pkg::PRESCALER_ADDR, 32'hFF);
        apb(1, halt_wake_pkg::CTRL_STATUS_ADDR, 32'h03);
        repeat (10) @(posedge ref_clk);
        #1 check({rc_on, cap_in}, 2'b11);
        {lite_en, ovf_en, wdg_opt, fetch} = '0;
        halt();
        check(wdg, 1);
        @(posedge ref_clk);
        wake_reset_req <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wake_reset_req <= 1'b0;
        wait_hi(0); check(n >= 240 && n <= 265 && fetch == 1, 1);
        check(pll_ok, 0);
        repeat (halt_wake_pkg::PLL_START_CYC) @(posedge ref_clk);
        #1 check(pll_ok, 1);
        $display("test reset wake done");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
